/* rtl/bcbde_pkg.sv */
// ==========================================================
// shared constants of the branch, call, bcd and decrement unit
package bcbde_pkg;

	// ==========================================================
	// opcode patterns
	localparam logic [7:0] BRANCH_ZERO_UPPER = 8'hE0;
	localparam logic [6:0] CALL_TOP = 7'h76;
	localparam logic [3:0] CALL_SECOND_TOP = 4'hF;
	localparam logic [15:0] ADJUST_WORD = 16'h0007;
	localparam logic [5:0] DECREMENT_TOP = 6'h01;
	localparam int CALL_FAST_BIT = 8;
	localparam int DECREMENT_DEST_BIT = 9;
	localparam int DECREMENT_ACCESS_BIT = 8;

	// ==========================================================
	// flag positions inside the status byte
	localparam int FLAG_C = 0;
	localparam int FLAG_DIGIT_CARRY = 1;
	localparam int FLAG_Z = 2;
	localparam int FLAG_OVERFLOW = 3;
	localparam int FLAG_N = 4;

	// ==========================================================
	// file addressing
	localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
	localparam logic [7:0] ACCESS_SPLIT = 8'h60;
	localparam logic [3:0] ACCESS_HIGH_PAGE = 4'hF;
	localparam logic [3:0] ACCESS_LOW_PAGE = 4'h0;

	// ==========================================================
	// register offsets (byte addresses)
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_WORKING = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_BANK_SELECT = 8'h0C;
	localparam logic [7:0] REG_PC = 8'h10;
	localparam logic [7:0] REG_TOP_OF_STACK = 8'h14;
	localparam logic [7:0] REG_STACK_PTR = 8'h18;
	localparam logic [7:0] REG_WORKING_SHADOW = 8'h1C;
	localparam logic [7:0] REG_FLAGS_SHADOW = 8'h20;
	localparam logic [7:0] REG_BANK_SHADOW = 8'h24;
	localparam logic [7:0] REG_INDEX_BASE = 8'h28;
	localparam int CTRL_EXT_BIT = 0;

	// ==========================================================
	// reset values and last quarter index
	localparam logic [20:0] RESET_PC = 21'h000000;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [11:0] RESET_INDEX_BASE = 12'h000;
	localparam logic [1:0] QUARTER_LAST = 2'h3;

endpackage

/* rtl/bcbde_exec.sv */
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - taken branch-on-zero loads PC plus twice offset
// - branch-on-zero decoded from upper byte E0
// - taken branch two cycles, untaken one
// - call pushes call address plus four
// - fast bit copies working, status, bank shadows
// - call literal loads PC bits 20 to 1
// - call decoded from two words with fast bit
// - call takes two instruction cycles
// - low nibble plus six above nine or digit carry
// - high nibble adjust with carry; only C changes
// - decimal adjust fixed opcode, one cycle
// - decrement file, destination bit picks target
// - access bit zero selects access bank
// - indexed offset when extended and address low
// - decrement updates carry, digit carry, N, overflow, Z
// - decrement decoded from 000001 d a f
// - decrement completes in one cycle
module bcbde_exec #(
	parameter int STACK_DEPTH = 31,
	parameter int SP_W = 5
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic instr_valid,
	input wire logic [15:0] instr_word,
	input wire logic [15:0] instr_next_word,
	input wire logic [7:0] file_rdata,
	input wire logic [7:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [31:0] bus_rdata,
	output logic [1:0] quarter,
	output logic [20:0] pc,
	output logic flush,
	output logic [11:0] file_addr,
	output logic file_re,
	output logic file_we,
	output logic [7:0] file_wdata
);

	// ==========================================================
	// types
	typedef enum logic [2:0] {OP_NONE, OP_BRANCH, OP_CALL, OP_ADJUST, OP_DECREMENT} bcbde_op_type;
	typedef enum logic {ST_EXEC, ST_NOP} bcbde_cycle_type;

	typedef struct packed {
		logic [1:0] q;
		bcbde_cycle_type st;
		bcbde_op_type op;
		logic [15:0] ir;
		logic [15:0] ir2;
		logic [20:0] pc;
		logic [7:0] w;
		logic [7:0] status;
		logic [7:0] bank_sel;
		logic [7:0] w_shadow;
		logic [7:0] ss;
		logic [7:0] bs;
		logic [SP_W-1:0] sp;
		logic [STACK_DEPTH:0][20:0] stk;
		logic ext_en;
		logic [11:0] index_base;
		logic [7:0] opr;
		logic [11:0] file_addr;
		logic file_re;
		logic file_we;
		logic [7:0] file_wdata;
		logic flush;
		logic [31:0] rdata;
	} bcbde_state_type;

	bcbde_state_type r;
	bcbde_state_type next_r;

	// ==========================================================
	// functions
	// file address from operand, access bit, mode and bank
	function automatic logic [11:0] bcbde_file_addr(input logic [7:0] f, input logic a, input logic ext,
		input logic [7:0] bank, input logic [11:0] base);
		logic [11:0] addr;
		addr = {bank[3:0], f};
		if (!a) begin
			if (ext && f <= bcbde_pkg::INDEXED_LIMIT) begin
				addr = 12'(base + {4'h0, f});
			end else if (f < bcbde_pkg::ACCESS_SPLIT) begin
				addr = {bcbde_pkg::ACCESS_LOW_PAGE, f};
			end else begin
				addr = {bcbde_pkg::ACCESS_HIGH_PAGE, f};
			end
		end
		return addr;
	endfunction

	// packed bcd correction, returns carry then byte
	function automatic logic [8:0] bcbde_adjust(input logic [7:0] w, input logic c, input logic dcarry);
		logic [4:0] lo;
		logic [4:0] hi;
		lo = {1'b0, w[3:0]};
		if (w[3:0] > 4'h9 || dcarry) begin
			lo = 5'(lo + 5'h06);
		end
		hi = 5'({1'b0, w[7:4]} + {4'h0, lo[4]});
		if (hi > 5'h09 || c) begin
			hi = 5'(hi + 5'h06);
		end
		return {hi[4] | c, hi[3:0], lo[3:0]};
	endfunction

	// register read mux
	function automatic logic [31:0] bcbde_read(input bcbde_state_type s, input logic [7:0] addr);
		logic [31:0] d;
		d = 32'h00000000;
		case (addr)
			bcbde_pkg::REG_CTRL: d[bcbde_pkg::CTRL_EXT_BIT] = s.ext_en;
			bcbde_pkg::REG_WORKING: d[7:0] = s.w;
			bcbde_pkg::REG_STATUS: d[7:0] = s.status;
			bcbde_pkg::REG_BANK_SELECT: d[7:0] = s.bank_sel;
			bcbde_pkg::REG_PC: d[20:0] = s.pc;
			bcbde_pkg::REG_TOP_OF_STACK: d[20:0] = s.stk[s.sp];
			bcbde_pkg::REG_STACK_PTR: d[SP_W-1:0] = s.sp;
			bcbde_pkg::REG_WORKING_SHADOW: d[7:0] = s.w_shadow;
			bcbde_pkg::REG_FLAGS_SHADOW: d[7:0] = s.ss;
			bcbde_pkg::REG_BANK_SHADOW: d[7:0] = s.bs;
			bcbde_pkg::REG_INDEX_BASE: d[11:0] = s.index_base;
			default: d = 32'h00000000;
		endcase
		return d;
	endfunction

	// ==========================================================
	// combinational helpers
	logic z_set;
	logic [20:0] branch_offset;
	logic [8:0] adjust_res;
	logic [7:0] dec_res;
	assign z_set = r.status[bcbde_pkg::FLAG_Z];
	assign branch_offset = {{12{r.ir[7]}}, r.ir[7:0], 1'b0};
	assign adjust_res = bcbde_adjust(r.w, r.status[bcbde_pkg::FLAG_C], r.status[bcbde_pkg::FLAG_DIGIT_CARRY]);
	assign dec_res = 8'(r.opr - 8'h01);

	// ==========================================================
	// next state: quarter phases, execution, then bus writes
	always_comb begin
		next_r = r;
		next_r.q = 2'(r.q + 2'h1);
		next_r.flush = 1'b0;
		next_r.file_re = 1'b0;
		next_r.file_we = 1'b0;
		case (r.q)
			2'h0: begin
				// q1 decode
				next_r.op = OP_NONE;
				if (r.st == ST_EXEC && instr_valid) begin
					next_r.ir = instr_word;
					next_r.ir2 = instr_next_word;
					next_r.pc = 21'(r.pc + 21'h000002);
					if (instr_word[15:8] == bcbde_pkg::BRANCH_ZERO_UPPER) begin
						next_r.op = OP_BRANCH;
					end else if (instr_word[15:9] == bcbde_pkg::CALL_TOP &&
						instr_next_word[15:12] == bcbde_pkg::CALL_SECOND_TOP) begin
						next_r.op = OP_CALL;
					end else if (instr_word == bcbde_pkg::ADJUST_WORD) begin
						next_r.op = OP_ADJUST;
					end else if (instr_word[15:10] == bcbde_pkg::DECREMENT_TOP) begin
						next_r.op = OP_DECREMENT;
						next_r.file_addr = bcbde_file_addr(instr_word[7:0],
							instr_word[bcbde_pkg::DECREMENT_ACCESS_BIT], r.ext_en, r.bank_sel, r.index_base);
						next_r.file_re = 1'b1;
					end
				end
			end
			2'h1: begin
				// q2 operand read is in flight
				next_r.op = r.op;
			end
			2'h2: begin
				// q3 take file data, push for a call
				if (r.op == OP_DECREMENT) begin
					next_r.opr = file_rdata;
				end
				if (r.op == OP_CALL) begin
					if (r.sp < SP_W'(STACK_DEPTH)) begin
						next_r.sp = SP_W'(r.sp + 1'b1);
						next_r.stk[SP_W'(r.sp + 1'b1)] = 21'(r.pc + 21'h000002);
					end
					if (r.ir[bcbde_pkg::CALL_FAST_BIT]) begin
						next_r.w_shadow = r.w;
						next_r.ss = r.status;
						next_r.bs = r.bank_sel;
					end
				end
			end
			default: begin
				// q4 write results
				next_r.st = ST_EXEC;
				case (r.op)
					OP_BRANCH: begin
						if (z_set) begin
							next_r.pc = 21'(r.pc + branch_offset);
							next_r.flush = 1'b1;
							next_r.st = ST_NOP;
						end
					end
					OP_CALL: begin
						next_r.pc = {r.ir2[11:0], r.ir[7:0], 1'b0};
						next_r.flush = 1'b1;
						next_r.st = ST_NOP;
					end
					OP_ADJUST: begin
						next_r.w = adjust_res[7:0];
						next_r.status[bcbde_pkg::FLAG_C] = adjust_res[8];
					end
					OP_DECREMENT: begin
						if (r.ir[bcbde_pkg::DECREMENT_DEST_BIT]) begin
							next_r.file_wdata = dec_res;
							next_r.file_we = 1'b1;
						end else begin
							next_r.w = dec_res;
						end
						next_r.status[bcbde_pkg::FLAG_C] = (r.opr != 8'h00);
						next_r.status[bcbde_pkg::FLAG_DIGIT_CARRY] = (r.opr[3:0] != 4'h0);
						next_r.status[bcbde_pkg::FLAG_Z] = (dec_res == 8'h00);
						next_r.status[bcbde_pkg::FLAG_N] = dec_res[7];
						next_r.status[bcbde_pkg::FLAG_OVERFLOW] = (r.opr == 8'h80);
					end
					default: begin
						next_r.st = ST_EXEC;
					end
				endcase
			end
		endcase
		// software access, writes land after the core
		if (bus_rd) begin
			next_r.rdata = bcbde_read(r, bus_addr);
		end
		if (bus_wr) begin
			case (bus_addr)
				bcbde_pkg::REG_CTRL: next_r.ext_en = bus_wdata[bcbde_pkg::CTRL_EXT_BIT];
				bcbde_pkg::REG_WORKING: next_r.w = bus_wdata[7:0];
				bcbde_pkg::REG_STATUS: next_r.status = bus_wdata[7:0];
				bcbde_pkg::REG_BANK_SELECT: next_r.bank_sel = bus_wdata[7:0];
				bcbde_pkg::REG_PC: next_r.pc = {bus_wdata[20:1], 1'b0};
				bcbde_pkg::REG_INDEX_BASE: next_r.index_base = bus_wdata[11:0];
				default: next_r.ext_en = next_r.ext_en;
			endcase
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			r <= '0;
			r.st <= ST_EXEC;
			r.op <= OP_NONE;
			r.pc <= bcbde_pkg::RESET_PC;
			r.w <= bcbde_pkg::RESET_BYTE;
			r.status <= bcbde_pkg::RESET_BYTE;
			r.bank_sel <= bcbde_pkg::RESET_BYTE;
			r.index_base <= bcbde_pkg::RESET_INDEX_BASE;
		end else if (clk_en) begin
			r <= next_r;
		end
	end

	// ==========================================================
	// outputs straight from the state register
	assign bus_rdata = r.rdata;
	assign quarter = r.q;
	assign pc = r.pc;
	assign flush = r.flush;
	assign file_addr = r.file_addr;
	assign file_re = r.file_re;
	assign file_we = r.file_we;
	assign file_wdata = r.file_wdata;

	// ==========================================================
	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst || !clk_en);

	logic q4_branch;
	logic q4_call;
	logic q4_dec;
	assign q4_branch = r.q == bcbde_pkg::QUARTER_LAST && r.op == OP_BRANCH;
	assign q4_call = r.q == bcbde_pkg::QUARTER_LAST && r.op == OP_CALL;
	assign q4_dec = r.q == bcbde_pkg::QUARTER_LAST && r.op == OP_DECREMENT;

	AST_BRANCH_TARGET: assert property (q4_branch && z_set && !bus_wr
		|=> r.pc == 21'($past(r.pc) + $past(branch_offset)))
		else $error("taken branch target wrong");
	AST_BRANCH_FLAGS: assert property (q4_branch && !bus_wr |=> $stable(r.status))
		else $error("branch changed flags");
	AST_BRANCH_DECODE: assert property (r.q == 2'h0 && r.st == ST_EXEC && instr_valid &&
		instr_word[15:8] == bcbde_pkg::BRANCH_ZERO_UPPER |=> r.op == OP_BRANCH)
		else $error("branch not decoded");
	AST_BRANCH_TAKEN_CYCLES: assert property (q4_branch && z_set |=> r.flush && r.st == ST_NOP
		##1 (r.st == ST_NOP)[*3] ##1 r.st == ST_EXEC)
		else $error("taken branch not two cycles");
	AST_BRANCH_UNTAKEN: assert property (q4_branch && !z_set |=> !r.flush && r.st == ST_EXEC)
		else $error("untaken branch stalled");
	AST_CALL_PUSH: assert property (r.q == 2'h2 && r.op == OP_CALL && r.sp < SP_W'(STACK_DEPTH) && !bus_wr
		|=> r.sp == SP_W'($past(r.sp) + 1'b1) && r.stk[r.sp] == 21'($past(r.pc) + 21'h000002))
		else $error("return address push wrong");
	AST_SHADOW_HOLD: assert property (r.q == 2'h2 && r.op == OP_CALL && !r.ir[bcbde_pkg::CALL_FAST_BIT]
		|=> $stable(r.w_shadow) && $stable(r.ss) && $stable(r.bs))
		else $error("shadows changed without fast save");
	AST_SHADOW_SAVE: assert property (r.q == 2'h2 && r.op == OP_CALL && r.ir[bcbde_pkg::CALL_FAST_BIT]
		|=> r.w_shadow == $past(r.w) && r.ss == $past(r.status) && r.bs == $past(r.bank_sel))
		else $error("fast save missed");
	AST_CALL_TARGET: assert property (q4_call && !bus_wr
		|=> r.pc == {$past(r.ir2[11:0]), $past(r.ir[7:0]), 1'b0} && r.flush && r.st == ST_NOP)
		else $error("call target wrong");
	AST_ADJUST_ONLY_C: assert property (r.q == bcbde_pkg::QUARTER_LAST && r.op == OP_ADJUST && !bus_wr
		|=> r.status[7:1] == $past(r.status[7:1]))
		else $error("adjust touched other flags");
	AST_DEC_TO_W: assert property (q4_dec && !r.ir[bcbde_pkg::DECREMENT_DEST_BIT] && !bus_wr
		|=> r.w == 8'($past(r.opr) - 8'h01) && !r.file_we)
		else $error("decrement to working wrong");
	AST_DEC_TO_F: assert property (q4_dec && r.ir[bcbde_pkg::DECREMENT_DEST_BIT]
		|=> r.file_we && r.file_wdata == 8'($past(r.opr) - 8'h01) ##1 !r.file_we)
		else $error("decrement write back wrong");
	AST_DEC_BANK: assert property (r.q == 2'h0 && r.st == ST_EXEC && instr_valid &&
		instr_word[15:10] == bcbde_pkg::DECREMENT_TOP && instr_word[bcbde_pkg::DECREMENT_ACCESS_BIT]
		|=> r.file_re && r.file_addr == {$past(r.bank_sel[3:0]), $past(instr_word[7:0])})
		else $error("banked address wrong");
	AST_DEC_ZERO: assert property (q4_dec && !bus_wr
		|=> r.status[bcbde_pkg::FLAG_Z] == ($past(r.opr) == 8'h01))
		else $error("decrement zero flag wrong");

	COV_BRANCH_TAKEN: cover property (q4_branch && z_set);
	COV_CALL_FAST: cover property (q4_call && r.ir[bcbde_pkg::CALL_FAST_BIT]);
	COV_ADJUST_CARRY: cover property (r.q == bcbde_pkg::QUARTER_LAST && r.op == OP_ADJUST && adjust_res[8]);
	COV_DEC_FILE: cover property (q4_dec && r.ir[bcbde_pkg::DECREMENT_DEST_BIT]);

endmodule

`default_nettype wire

/* dv/branch_call_bcd_decrement_exec_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module branch_call_bcd_decrement_exec_tb_top;
	logic sys_clk, rst, clk_en, instr_valid, bus_wr, bus_rd, flush, file_re, file_we;
	logic [15:0] instr_word, instr_next_word;
	logic [7:0] file_rdata, bus_addr, file_wdata, we_data;
	logic [31:0] bus_wdata, bus_rdata;
	logic [1:0] quarter;
	logic [20:0] pc;
	logic [11:0] file_addr, we_addr;
	int num_errors = 0;
	int n_tests = 0;
	int we_cnt = 0;
	int fl_cnt = 0;
	int re_cnt = 0;
	int c0, i;
	// decimal adjust cases: w in, status in, w out, status out
	logic [7:0] adj_t [0:2][0:3] = '{'{8'hA5, 8'h00, 8'h05, 8'h01}, '{8'hCE, 8'h00, 8'h34, 8'h01},
		'{8'h23, 8'h02, 8'h29, 8'h02}};
	// decrement addressing cases: ctrl, opcode, expected file address
	logic [15:0] adr_t [0:3][0:2] = '{'{16'h0000, 16'h0660, 16'h0F60}, '{16'h0001, 16'h0605, 16'h0205},
		'{16'h0001, 16'h065F, 16'h025F}, '{16'h0001, 16'h0660, 16'h0F60}};
	// branch cases: status, opcode, expected pc, flush count
	logic [20:0] br_t [0:3][0:3] = '{'{21'h4, 21'hE0FE, 21'h1FE, 21'h1}, '{21'h4, 21'hE07F, 21'h300, 21'h1},
		'{21'h4, 21'hE080, 21'h102, 21'h1}, '{21'h0, 21'hE0FE, 21'h202, 21'h0}};

	bcbde_exec #(.STACK_DEPTH(31), .SP_W(5)) DUT (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
		.instr_valid(instr_valid), .instr_word(instr_word), .instr_next_word(instr_next_word),
		.file_rdata(file_rdata), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_rdata(bus_rdata), .quarter(quarter), .pc(pc), .flush(flush),
		.file_addr(file_addr), .file_re(file_re), .file_we(file_we), .file_wdata(file_wdata));

	// clock generation
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	// capture of file writes and flush pulses
	always @(posedge sys_clk) begin
		if (file_we === 1'b1) begin
			we_cnt <= we_cnt + 1;
			we_addr <= file_addr;
			we_data <= file_wdata;
		end
		if (flush === 1'b1) begin
			fl_cnt <= fl_cnt + 1;
		end
		if (file_re === 1'b1) begin
			re_cnt <= re_cnt + 1;
		end
	end

	// ==========================================================
	// bench tasks
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge sys_clk);
		bus_wr <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge sys_clk);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge sys_clk);
		bus_rd <= 1'b0;
		@(negedge sys_clk);
		chk(bus_rdata, exp);
	endtask

	// offer one instruction in quarter 0, then wait out result and bubble
	task automatic exec(input logic [15:0] w, input logic [15:0] nw);
		int k;
		for (k = 0; k < 8; k++) begin
			@(negedge sys_clk);
			if (quarter === 2'h3) break;
		end
		if (k == 8) begin
			num_errors++;
			conclude();
		end
		@(posedge sys_clk);
		instr_valid <= 1'b1;
		instr_word <= w;
		instr_next_word <= nw;
		@(posedge sys_clk);
		instr_valid <= 1'b0;
		repeat (8) @(posedge sys_clk);
	endtask

	// hang guard
	initial begin
		#2000000;
		num_errors++;
		conclude();
	end

	// ==========================================================
	// main sequence
	initial begin
		rst = 1'b1;
		clk_en = 1'b1;
		instr_valid = 1'b0;
		instr_word = 16'h0000;
		instr_next_word = 16'h0000;
		file_rdata = 8'h00;
		bus_addr = 8'h00;
		bus_wdata = 32'h0;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		rchk(bcbde_pkg::REG_PC, 32'h0);
		rchk(bcbde_pkg::REG_STACK_PTR, 32'h0);
		rchk(8'hFC, 32'h0);
		$display("test reset done");
		for (i = 0; i < 3; i++) begin
			wr(bcbde_pkg::REG_WORKING, {24'h0, adj_t[i][0]});
			wr(bcbde_pkg::REG_STATUS, {24'h0, adj_t[i][1]});
			exec(16'h0007, 16'h0000);
			rchk(bcbde_pkg::REG_WORKING, {24'h0, adj_t[i][2]});
			rchk(bcbde_pkg::REG_STATUS, {24'h0, adj_t[i][3]});
		end
		$display("test decimal adjust done");
		wr(bcbde_pkg::REG_STATUS, 32'h0);
		file_rdata <= 8'h01;
		c0 = we_cnt;
		exec(16'h0610, 16'h0000);
		chk(32'(we_cnt), 32'(c0 + 1));
		chk(32'(re_cnt), 32'h1);
		chk({20'h0, we_addr}, 32'h010);
		chk({24'h0, we_data}, 32'h00);
		rchk(bcbde_pkg::REG_STATUS, 32'h07);
		wr(bcbde_pkg::REG_BANK_SELECT, 32'h3);
		file_rdata <= 8'h80;
		exec(16'h0580, 16'h0000);
		chk(32'(we_cnt), 32'(c0 + 1));
		rchk(bcbde_pkg::REG_WORKING, 32'h7F);
		chk({20'h0, file_addr}, 32'h380);
		rchk(bcbde_pkg::REG_STATUS, 32'h09);
		wr(bcbde_pkg::REG_INDEX_BASE, 32'h200);
		for (i = 0; i < 4; i++) begin
			wr(bcbde_pkg::REG_CTRL, {16'h0, adr_t[i][0]});
			exec(adr_t[i][1], 16'h0000);
			chk({20'h0, we_addr}, {16'h0, adr_t[i][2]});
		end
		wr(bcbde_pkg::REG_CTRL, 32'h0);
		$display("test decrement done");
		for (i = 0; i < 4; i++) begin
			wr(bcbde_pkg::REG_STATUS, {11'h0, br_t[i][0]});
			wr(bcbde_pkg::REG_PC, 32'h200);
			c0 = fl_cnt;
			exec(br_t[i][1][15:0], 16'h0000);
			rchk(bcbde_pkg::REG_PC, {11'h0, br_t[i][2]});
			chk({11'h0, pc}, {11'h0, br_t[i][2]});
			rchk(bcbde_pkg::REG_STATUS, {11'h0, br_t[i][0]});
			chk(32'(fl_cnt - c0), {11'h0, br_t[i][3]});
		end
		$display("test branch done");
		// calls with and without fast save
		wr(bcbde_pkg::REG_WORKING, 32'h5A);
		wr(bcbde_pkg::REG_STATUS, 32'h13);
		wr(bcbde_pkg::REG_BANK_SELECT, 32'h07);
		wr(bcbde_pkg::REG_PC, 32'h100);
		c0 = fl_cnt;
		exec(16'hEDDE, 16'hFABC);
		rchk(bcbde_pkg::REG_PC, 32'h1579BC);
		rchk(bcbde_pkg::REG_TOP_OF_STACK, 32'h104);
		rchk(bcbde_pkg::REG_STACK_PTR, 32'h1);
		rchk(bcbde_pkg::REG_WORKING_SHADOW, 32'h5A);
		rchk(bcbde_pkg::REG_FLAGS_SHADOW, 32'h13);
		rchk(bcbde_pkg::REG_BANK_SHADOW, 32'h07);
		chk(32'(fl_cnt - c0), 32'h1);
		wr(bcbde_pkg::REG_WORKING, 32'h11);
		exec(16'hEC34, 16'hF001);
		rchk(bcbde_pkg::REG_PC, 32'h268);
		rchk(bcbde_pkg::REG_TOP_OF_STACK, 32'h1579C0);
		rchk(bcbde_pkg::REG_STACK_PTR, 32'h2);
		rchk(bcbde_pkg::REG_WORKING_SHADOW, 32'h5A);
		$display("test call done");
		conclude();
	end
endmodule

`default_nettype wire
